// >>> verilog/open_load_pkg.sv
// constants for the open-load status register pair
// assumes the serial front end hands over a 5-bit register address field
`default_nettype none
package open_load_pkg;
   localparam int unsigned   REG_W             = 8;
   localparam int unsigned   ADDR_W            = 5;
   localparam int unsigned   BRIDGES_PER_REG   = 4;
   localparam int unsigned   SYNC_STAGES       = 2;
   // address field patterns (3-bit group, 2-bit index)
   localparam logic [4:0]    ADDR_BRIDGES_1_TO_4 = 5'h09;
   localparam logic [4:0]    ADDR_BRIDGES_5_TO_8 = 5'h11;
   // bit position of each switch within its bridge pair
   localparam int unsigned   HIGH_SIDE_POS     = 1;
   localparam int unsigned   LOW_SIDE_POS      = 0;
   localparam logic [7:0]    FLAGS_RESET       = 8'h00;
endpackage
`default_nettype wire

// >>> verilog/open_load_flag_bank.sv
// a row of sticky fault flags with clear-on-read
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module open_load_flag_bank #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic             clr_in,
   output logic      [WIDTH-1:0] flags
);
   logic [WIDTH-1:0] flags_r;
   logic [WIDTH-1:0] flags_nxt;

   // a new event beats a clearing read
   assign flags_nxt = (clr_in ? {WIDTH{1'b0}} : flags_r) | set_in;
   assign flags     = flags_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flags_r <= {WIDTH{1'b0}};
      end else begin
         flags_r <= flags_nxt;
      end
   end
endmodule // open_load_flag_bank
`default_nettype wire

// >>> verilog/open_load_status_regs.sv
// open-load status registers for eight half bridges, read-clear
// assumes detector levels are asynchronous; read requests come on clk
// assumes the serial front end turns each frame into rd_req and rd_addr
`timescale 1ns/1ps
`default_nettype none
module open_load_status_regs #(
   parameter int unsigned BRIDGES = 8
) (
   input  wire logic                             clk,
   input  wire logic                             nrst,
   input  wire logic [BRIDGES-1:0]               open_high_det,
   input  wire logic [BRIDGES-1:0]               open_low_det,
   input  wire logic                             rd_req,
   input  wire logic [open_load_pkg::ADDR_W-1:0] rd_addr,
   output logic      [open_load_pkg::REG_W-1:0]  rd_data_r,
   output logic                                  rd_valid_r,
   output logic                                  rd_miss_r
);
   import open_load_pkg::*;

   // bit of one switch inside its register
   function automatic int unsigned pair_bit(input int unsigned bridge_idx,
                                            input int unsigned side_pos);
      return 2*bridge_idx + side_pos;
   endfunction

   // interleave high/low flags, highest bridge at the top
   function automatic logic [REG_W-1:0] pack_pairs(input logic [BRIDGES_PER_REG-1:0] hi,
                                                   input logic [BRIDGES_PER_REG-1:0] lo);
      logic [REG_W-1:0] v;
      v = FLAGS_RESET;
      for (int i = 0; i < BRIDGES_PER_REG; i++) begin
         v[pair_bit(i, HIGH_SIDE_POS)] = hi[i];
         v[pair_bit(i, LOW_SIDE_POS)]  = lo[i];
      end
      return v;
   endfunction

   // a read aimed at one register
   function automatic logic addr_match(input logic              req,
                                       input logic [ADDR_W-1:0] addr,
                                       input logic [ADDR_W-1:0] target);
      return req && (addr == target);
   endfunction

   // two-stage synchronisers for the detector levels
   logic [BRIDGES-1:0] high_meta_r;
   logic [BRIDGES-1:0] high_sync_r;
   logic [BRIDGES-1:0] low_meta_r;
   logic [BRIDGES-1:0] low_sync_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         high_meta_r <= '0;
      end else begin
         high_meta_r <= open_high_det;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         high_sync_r <= '0;
      end else begin
         high_sync_r <= high_meta_r;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         low_meta_r <= '0;
      end else begin
         low_meta_r <= open_low_det;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         low_sync_r <= '0;
      end else begin
         low_sync_r <= low_meta_r;
      end
   end

   wire logic [REG_W-1:0] set_lower;
   wire logic [REG_W-1:0] set_upper;
   wire logic [REG_W-1:0] flags_lower;
   wire logic [REG_W-1:0] flags_upper;

   assign set_lower = pack_pairs(high_sync_r[BRIDGES_PER_REG-1:0], low_sync_r[BRIDGES_PER_REG-1:0]);
   assign set_upper = pack_pairs(high_sync_r[2*BRIDGES_PER_REG-1:BRIDGES_PER_REG],
                                 low_sync_r[2*BRIDGES_PER_REG-1:BRIDGES_PER_REG]);

   // address decode
   wire logic hit_lower;
   wire logic hit_upper;
   wire logic hit_any;

   assign hit_lower = addr_match(rd_req, rd_addr, ADDR_BRIDGES_1_TO_4);
   assign hit_upper = addr_match(rd_req, rd_addr, ADDR_BRIDGES_5_TO_8);
   assign hit_any   = hit_lower || hit_upper;

   // sticky flag rows, one per register
   open_load_flag_bank #(
      .WIDTH (REG_W)
   ) u_lower (
      .clk    (clk),
      .nrst   (nrst),
      .set_in (set_lower),
      .clr_in (hit_lower),
      .flags  (flags_lower)
   );

   open_load_flag_bank #(
      .WIDTH (REG_W)
   ) u_upper (
      .clk    (clk),
      .nrst   (nrst),
      .set_in (set_upper),
      .clr_in (hit_upper),
      .flags  (flags_upper)
   );

   // latched flag of each switch, by name
   wire logic bridge1_high_open_flag;
   wire logic bridge1_low_open_flag;
   wire logic bridge2_high_open_flag;
   wire logic bridge2_low_open_flag;
   wire logic bridge3_high_open_flag;
   wire logic bridge3_low_open_flag;
   wire logic bridge4_high_open_flag;
   wire logic bridge4_low_open_flag;

   wire logic bridge5_high_open_flag;
   wire logic bridge5_low_open_flag;
   wire logic bridge6_high_open_flag;
   wire logic bridge6_low_open_flag;
   wire logic bridge7_high_open_flag;
   wire logic bridge7_low_open_flag;
   wire logic bridge8_high_open_flag;
   wire logic bridge8_low_open_flag;

   assign bridge1_high_open_flag = flags_lower[pair_bit(0, HIGH_SIDE_POS)];
   assign bridge1_low_open_flag  = flags_lower[pair_bit(0, LOW_SIDE_POS)];

   assign bridge2_high_open_flag = flags_lower[pair_bit(1, HIGH_SIDE_POS)];
   assign bridge2_low_open_flag  = flags_lower[pair_bit(1, LOW_SIDE_POS)];

   assign bridge3_high_open_flag = flags_lower[pair_bit(2, HIGH_SIDE_POS)];
   assign bridge3_low_open_flag  = flags_lower[pair_bit(2, LOW_SIDE_POS)];

   assign bridge4_high_open_flag = flags_lower[pair_bit(3, HIGH_SIDE_POS)];
   assign bridge4_low_open_flag  = flags_lower[pair_bit(3, LOW_SIDE_POS)];

   assign bridge5_high_open_flag = flags_upper[pair_bit(0, HIGH_SIDE_POS)];
   assign bridge5_low_open_flag  = flags_upper[pair_bit(0, LOW_SIDE_POS)];

   assign bridge6_high_open_flag = flags_upper[pair_bit(1, HIGH_SIDE_POS)];
   assign bridge6_low_open_flag  = flags_upper[pair_bit(1, LOW_SIDE_POS)];

   assign bridge7_high_open_flag = flags_upper[pair_bit(2, HIGH_SIDE_POS)];
   assign bridge7_low_open_flag  = flags_upper[pair_bit(2, LOW_SIDE_POS)];

   assign bridge8_high_open_flag = flags_upper[pair_bit(3, HIGH_SIDE_POS)];
   assign bridge8_low_open_flag  = flags_upper[pair_bit(3, LOW_SIDE_POS)];

   // register images, highest bridge first
   wire logic [REG_W-1:0] open_load_flags_bridges_1_to_4;
   wire logic [REG_W-1:0] open_load_flags_bridges_5_to_8;

   assign open_load_flags_bridges_1_to_4 = {bridge4_high_open_flag, bridge4_low_open_flag,
                                            bridge3_high_open_flag, bridge3_low_open_flag,
                                            bridge2_high_open_flag, bridge2_low_open_flag,
                                            bridge1_high_open_flag, bridge1_low_open_flag};

   assign open_load_flags_bridges_5_to_8 = {bridge8_high_open_flag, bridge8_low_open_flag,
                                            bridge7_high_open_flag, bridge7_low_open_flag,
                                            bridge6_high_open_flag, bridge6_low_open_flag,
                                            bridge5_high_open_flag, bridge5_low_open_flag};

   wire logic [REG_W-1:0] rd_data_nxt;
   wire logic             rd_valid_nxt;
   wire logic             rd_miss_nxt;

   assign rd_data_nxt  = hit_lower ? open_load_flags_bridges_1_to_4 :
                         hit_upper ? open_load_flags_bridges_5_to_8 : FLAGS_RESET;
   assign rd_valid_nxt = rd_req;
   assign rd_miss_nxt  = rd_req && !hit_any;

   // read answer: value before the clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_data_r <= FLAGS_RESET;
      end else begin
         rd_data_r <= rd_data_nxt;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= rd_valid_nxt;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_miss_r <= 1'b0;
      end else begin
         rd_miss_r <= rd_miss_nxt;
      end
   end
endmodule // open_load_status_regs
`default_nettype wire

// >>> tb/open_load_host.sv
// host side: issues single register reads
// assumes the block samples rd_req on the rising edge
`timescale 1ns/1ps
`default_nettype none
module open_load_host (
   input  wire logic       clk,
   output var  logic       rd_req,
   output var  logic [4:0] rd_addr
);
   initial rd_req = 1'b0;
   initial rd_addr = 5'h00;
   task automatic rd(input logic [4:0] a);
      @(negedge clk);
      rd_req = 1'b1;
      rd_addr = a;
      @(negedge clk);
      rd_req = 1'b0;
      rd_addr = ~a;
   endtask
endmodule // open_load_host
`default_nettype wire

// >>> tb/open_load_status_regs_assertions.sv
// checker on the register pair ports
// assumes bound into open_load_status_regs
`timescale 1ns/1ps
`default_nettype none
module open_load_status_regs_assertions
   import open_load_pkg::*;
#(parameter int unsigned BRIDGES = 8) (
   input wire logic                             clk,
   input wire logic                             nrst,
   input wire logic [BRIDGES-1:0]               open_high_det,
   input wire logic [BRIDGES-1:0]               open_low_det,
   input wire logic                             rd_req,
   input wire logic [open_load_pkg::ADDR_W-1:0] rd_addr,
   input wire logic [open_load_pkg::REG_W-1:0]  rd_data_r,
   input wire logic                             rd_valid_r,
   input wire logic                             rd_miss_r
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence read_of(a);
      rd_req && rd_addr == a;
   endsequence
   sequence sync_ran;
      $past(nrst,3) && $past(nrst,2) && $past(nrst);
   endsequence
   wire logic hit = rd_addr inside {ADDR_BRIDGES_1_TO_4, ADDR_BRIDGES_5_TO_8};
   reset_quiet_a: assert property (!$past(nrst) |-> !rd_valid_r && rd_data_r == 8'h00) else $error("busy after reset");
   read_answer_a: assert property (rd_req |=> rd_valid_r) else $error("read not answered");
   idle_data_a: assert property (!rd_req |=> !rd_valid_r && rd_data_r == 8'h00) else $error("spurious answer");
   miss_zero_a: assert property (rd_req && !hit |=> rd_miss_r && rd_data_r == 8'h00) else $error("bad miss");
   hit_ok_a: assert property (rd_req && hit |=> !rd_miss_r) else $error("false miss");
   lower_map_a: assert property (read_of(ADDR_BRIDGES_1_TO_4) ##0 sync_ran ##0 $past(open_high_det[0],3)
      |=> rd_data_r[1]) else $error("lower bit order");
   upper_map_a: assert property (read_of(ADDR_BRIDGES_5_TO_8) ##0 sync_ran ##0 $past(open_low_det[6],3)
      |=> rd_data_r[4]) else $error("upper bit order");
endmodule // open_load_status_regs_assertions
bind open_load_status_regs open_load_status_regs_assertions #(.BRIDGES(BRIDGES)) open_load_status_regs_assertions_inst (.*);
`default_nettype wire

// >>> tb/open_load_status_regs_tb_top.sv
// testbench: reads the open-load registers through the host model
// assumes clk at 250 MHz and active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module open_load_status_regs_tb_top
   import open_load_pkg::*;
;
   logic            clk = 1'b0;
   logic            nrst = 1'b0;
   logic [7:0]      hi = 8'h00;
   logic [7:0]      lo = 8'h00;
   wire logic       rd_req, rd_valid_r, rd_miss_r;
   wire logic [4:0] rd_addr;
   wire logic [7:0] rd_data_r;
   int              n_mismatch = 0;
   int              tests_run = 0;
   initial forever #2 clk = ~clk;
   open_load_host open_load_host_inst (.clk(clk), .rd_req(rd_req), .rd_addr(rd_addr));
   open_load_status_regs open_load_status_regs_inst (.clk(clk), .nrst(nrst), .open_high_det(hi), .open_low_det(lo),
      .rd_req(rd_req), .rd_addr(rd_addr), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .rd_miss_r(rd_miss_r));
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [4:0] a, input logic [9:0] exp);
      open_load_host_inst.rd(a);
      chk({rd_valid_r, rd_miss_r, rd_data_r}, exp);
   endtask
   task automatic stop_test;
      $display("compared %0d, mismatched %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #2000;
      n_mismatch++;
      stop_test;
   end
   initial begin
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      rchk(ADDR_BRIDGES_1_TO_4, 10'h200);
      rchk(ADDR_BRIDGES_5_TO_8, 10'h200);
      $display("reset test done");
      hi = 8'h21;
      lo = 8'h42;
      @(negedge clk);
      hi = 8'h00;
      lo = 8'h00;
      repeat (4) @(negedge clk);
      rchk(5'h1f, 10'h300);
      rchk(ADDR_BRIDGES_1_TO_4, 10'h206);
      rchk(ADDR_BRIDGES_5_TO_8, 10'h218);
      rchk(ADDR_BRIDGES_5_TO_8, 10'h200);
      $display("map and clear test done");
      hi = 8'h01;
      lo = 8'h40;
      repeat (4) @(negedge clk);
      rchk(ADDR_BRIDGES_1_TO_4, 10'h202);
      rchk(ADDR_BRIDGES_5_TO_8, 10'h210);
      rchk(ADDR_BRIDGES_1_TO_4, 10'h202);
      $display("steady fault test done");
      hi = 8'h00;
      lo = 8'h00;
      repeat (4) @(negedge clk);
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      rchk(ADDR_BRIDGES_1_TO_4, 10'h200);
      rchk(ADDR_BRIDGES_5_TO_8, 10'h200);
      $display("mid-run reset test done");
      hi = 8'ha5;
      lo = 8'h3c;
      @(negedge clk);
      hi = 8'h00;
      lo = 8'h00;
      repeat (4) @(negedge clk);
      rchk(ADDR_BRIDGES_1_TO_4, 10'h272);
      rchk(ADDR_BRIDGES_5_TO_8, 10'h28d);
      $display("full map test done");
      stop_test;
   end
endmodule // open_load_status_regs_tb_top
`default_nettype wire
